// *** inc/pfo_pkg.sv ***
// Package of constants shared by the PWM fault, override and dead-time block
package pfo_pkg;

  // ******************************************************
  // Register byte offsets on the AHB-Lite bus
  // ******************************************************
  localparam logic [7:0] OFF_DT_SELECT  = 8'h00;
  localparam logic [7:0] OFF_FAULT_A    = 8'h04;
  localparam logic [7:0] OFF_FAULT_B    = 8'h08;
  localparam logic [7:0] OFF_OVERRIDE   = 8'h0C;
  localparam logic [7:0] OFF_DUTY_ONE   = 8'h10;
  localparam logic [7:0] OFF_DUTY_TWO   = 8'h14;
  localparam logic [7:0] OFF_DUTY_THREE = 8'h18;
  localparam logic [7:0] OFF_DUTY_FOUR  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h24;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;

  // ******************************************************
  // Reset values and writable masks
  // ******************************************************
  localparam logic [15:0] RST_DT_SELECT = 16'h0000;
  localparam logic [15:0] RST_FAULT     = 16'h0000;
  localparam logic [15:0] RST_OVERRIDE  = 16'hFF00;
  localparam logic [15:0] RST_DUTY      = 16'h0000;
  localparam logic [1:0]  RST_IRQ       = 2'b00;
  localparam logic [15:0] MASK_DT_SEL   = 16'h00FF;
  localparam logic [15:0] MASK_FAULT    = 16'hFF8F;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int FAULT_MODE_BIT  = 7;
  localparam int PAIR_ENABLE_LSB = 0;
  localparam int PIN_LEVEL_LSB   = 8;
  localparam int GEN_SELECT_LSB  = 8;
  localparam int MANUAL_LSB      = 0;
  localparam int IRQ_FAULT_A     = 0;
  localparam int IRQ_FAULT_B     = 1;

  // ******************************************************
  // Widths
  // ******************************************************
  localparam int PAIRS     = 4;
  localparam int DT_WIDTH  = 8;
  localparam int IRQ_WIDTH = 2;

endpackage : pfo_pkg

// *** hdl/pfo_deadtime.sv ***
// Dead-time insertion for one high/low output pair
`timescale 1ns/1ps
`default_nettype none

module pfo_deadtime (
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         gen_i,
  input  wire logic                         gen_low_i,
  input  wire logic                         independent_i,
  input  wire logic                         active_edge_unit_sel_i,
  input  wire logic                         inactive_edge_unit_sel_i,
  input  wire logic [pfo_pkg::DT_WIDTH-1:0] dt_a_i,
  input  wire logic [pfo_pkg::DT_WIDTH-1:0] dt_b_i,
  output logic                              high_o,
  output logic                              low_o
);

  typedef struct packed {
    logic                         last;
    logic [pfo_pkg::DT_WIDTH-1:0] count;
    logic                         high;
    logic                         low;
  } pfo_dt_state_type;

  pfo_dt_state_type s;
  pfo_dt_state_type next_s;

  // ******************************************************
  // Edge detection and dead-time countdown
  // ******************************************************
  // Both sides are off during the count so a complementary pair never shoots through
  always_comb begin
    next_s = s;
    if (independent_i) begin
      next_s.high  = gen_i;
      next_s.low   = gen_low_i;
      next_s.last  = gen_i;
      next_s.count = '0;
    end else if (gen_i != s.last) begin
      next_s.last = gen_i;
      next_s.high = 1'b0;
      next_s.low  = 1'b0;
      if (gen_i) begin
        next_s.count = active_edge_unit_sel_i ? dt_b_i : dt_a_i;
      end else begin
        next_s.count = inactive_edge_unit_sel_i ? dt_b_i : dt_a_i;
      end
    end else if (s.count != '0) begin
      next_s.count = s.count - 1'b1;
    end else begin
      next_s.high = s.last;
      next_s.low  = ~s.last;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign high_o = s.high;
  assign low_o  = s.low;

endmodule : pfo_deadtime

`default_nettype wire

// *** hdl/pfo_top.sv ***
// PWM output conditioning: dead time, fault override, manual override, duty registers
// Operation
// - Per generator, active-edge select bit: one picks unit B, zero unit A.
// - Per generator, inactive-edge select bit: one picks unit B, zero unit A.
// - Fault A per-pin levels: one forces pin active, zero inactive.
// - Fault A mode one makes fault A act cycle by cycle.
// - Fault A mode zero latches controlled pins at fault A levels.
// - Fault A pair enables; bit 3 is pair four, cleared bit leaves pair alone.
// - Fault B per-pin levels: one forces pin active, zero inactive.
// - Fault B mode one is cycle by cycle, zero latches at fault B levels.
// - Fault B pair enables; bit 3 is pair four, bit 0 pair one.
// - Both faults enabled and asserted on a pair: fault A levels win.
// - Generator select bit one lets generator drive pin; zero uses manual bit.
// - Manual bit drives pin active or inactive while generator select is cleared.
// - Four writable 16-bit duty values, reset to zero, per generator.
// - Unimplemented bits of select and fault registers ignore writes, read zero.
// - Complementary mode: low side is complement of high, with dead time.
`timescale 1ns/1ps
`default_nettype none

module pfo_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  // AHB-Lite slave
  input  wire logic                         hsel_i,
  input  wire logic [31:0]                  haddr_i,
  input  wire logic [1:0]                   htrans_i,
  input  wire logic                         hwrite_i,
  input  wire logic [2:0]                   hsize_i,
  input  wire logic [31:0]                  hwdata_i,
  input  wire logic                         hready_i,
  output logic                              hreadyout_o,
  output logic                              hresp_o,
  output logic [31:0]                       hrdata_o,
  // Generator side
  input  wire logic [3:0]                   gen_high_i,
  input  wire logic [3:0]                   gen_low_i,
  input  wire logic [3:0]                   pair_independent_i,
  input  wire logic                         period_start_i,
  input  wire logic [pfo_pkg::DT_WIDTH-1:0] dt_a_cycles_i,
  input  wire logic [pfo_pkg::DT_WIDTH-1:0] dt_b_cycles_i,
  // Pins
  input  wire logic                         fault_a_b_i,
  input  wire logic                         fault_b_b_i,
  output logic [3:0]                        high_side_output_o,
  output logic [3:0]                        low_side_output_o,
  // Duty values toward the comparators
  output logic [15:0]                       duty_value_one_o,
  output logic [15:0]                       duty_value_two_o,
  output logic [15:0]                       duty_value_three_o,
  output logic [15:0]                       duty_value_four_o,
  output logic                              irq_o
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [15:0]                    dt_select;
    logic [15:0]                    fault_a;
    logic [15:0]                    fault_b;
    logic [15:0]                    override;
    logic [3:0][15:0]               duty;
    logic [pfo_pkg::IRQ_WIDTH-1:0]  irq_status;
    logic [pfo_pkg::IRQ_WIDTH-1:0]  irq_enable;
    logic                           irq;
    logic [1:0]                     sync1;
    logic [1:0]                     sync2;
    logic [1:0]                     seen;
    logic [1:0]                     latched;
    logic [1:0]                     cycle;
    logic                           wr_pend;
    logic [7:0]                     wr_addr;
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           resp;
    logic [3:0]                     high;
    logic [3:0]                     low;
  } pfo_main_state_type;

  pfo_main_state_type s;
  pfo_main_state_type next_s;

  logic [3:0] dt_high;
  logic [3:0] dt_low;

  // ******************************************************
  // Helpers
  // ******************************************************
  // Bit position of a pin inside any per-pin byte: high side above low side
  function automatic int pin_pos(input int pair, input logic high_side);
    pin_pos = 2 * pair + (high_side ? 1 : 0);
  endfunction

  // Masked register update; unimplemented positions stay zero
  function automatic logic [15:0] masked(input logic [15:0] data, input logic [15:0] mask);
    masked = data & mask;
  endfunction

  // Final pin level with its priority chain
  function automatic logic pin_level(
    input logic        fa_on,
    input logic        fb_on,
    input logic [15:0] fa,
    input logic [15:0] fb,
    input logic [15:0] ovd,
    input logic        dt_out,
    input int          pos
  );
    if (fa_on) begin
      pin_level = fa[pfo_pkg::PIN_LEVEL_LSB + pos];
    end else if (fb_on) begin
      pin_level = fb[pfo_pkg::PIN_LEVEL_LSB + pos];
    end else if (ovd[pfo_pkg::GEN_SELECT_LSB + pos]) begin
      pin_level = dt_out;
    end else begin
      pin_level = ovd[pfo_pkg::MANUAL_LSB + pos];
    end
  endfunction

  // Register read mux
  function automatic logic [31:0] read_value(input pfo_main_state_type st, input logic [7:0] a);
    read_value = 32'h0000_0000;
    case (a)
      pfo_pkg::OFF_DT_SELECT:  read_value[15:0] = st.dt_select;
      pfo_pkg::OFF_FAULT_A:    read_value[15:0] = st.fault_a;
      pfo_pkg::OFF_FAULT_B:    read_value[15:0] = st.fault_b;
      pfo_pkg::OFF_OVERRIDE:   read_value[15:0] = st.override;
      pfo_pkg::OFF_DUTY_ONE:   read_value[15:0] = st.duty[0];
      pfo_pkg::OFF_DUTY_TWO:   read_value[15:0] = st.duty[1];
      pfo_pkg::OFF_DUTY_THREE: read_value[15:0] = st.duty[2];
      pfo_pkg::OFF_DUTY_FOUR:  read_value[15:0] = st.duty[3];
      pfo_pkg::OFF_IRQ_STATUS: read_value[pfo_pkg::IRQ_WIDTH-1:0] = st.irq_status;
      pfo_pkg::OFF_IRQ_ENABLE: read_value[pfo_pkg::IRQ_WIDTH-1:0] = st.irq_enable;
      default:                 read_value = 32'h0000_0000;
    endcase
  endfunction

  // ******************************************************
  // Dead-time units, one per pair
  // ******************************************************
  for (genvar p = 0; p < pfo_pkg::PAIRS; p++) begin : g_pair
    pfo_deadtime u_deadtime (
      .clk_i                    (clk_i),
      .rst_b_i                  (rst_b_i),
      .gen_i                    (gen_high_i[p]),
      .gen_low_i                (gen_low_i[p]),
      .independent_i            (pair_independent_i[p]),
      .active_edge_unit_sel_i   (s.dt_select[2 * p + 1]),
      .inactive_edge_unit_sel_i (s.dt_select[2 * p]),
      .dt_a_i                   (dt_a_cycles_i),
      .dt_b_i                   (dt_b_cycles_i),
      .high_o                   (dt_high[p]),
      .low_o                    (dt_low[p])
    );
  end

  // ******************************************************
  // Next-state logic
  // ******************************************************
  // Bus writes land in the data phase, one cycle after the address phase
  always_comb begin
    logic [1:0]                    asserted;
    logic [1:0]                    mode_cycle;
    logic [1:0]                    soft_release;
    logic [pfo_pkg::IRQ_WIDTH-1:0] events;
    logic [pfo_pkg::IRQ_WIDTH-1:0] clear;
    logic                          fa_on;
    logic                          fb_on;
    asserted     = 2'b00;
    mode_cycle   = 2'b00;
    soft_release = 2'b00;
    events       = '0;
    clear        = '0;
    fa_on        = 1'b0;
    fb_on        = 1'b0;
    next_s       = s;

    // Fault pins are active low and asynchronous
    next_s.sync1 = {~fault_b_b_i, ~fault_a_b_i};
    next_s.sync2 = s.sync1;
    next_s.seen  = s.sync2;
    asserted     = s.sync2;

    // Register writes
    if (s.wr_pend) begin
      case (s.wr_addr)
        pfo_pkg::OFF_DT_SELECT: begin
          next_s.dt_select = masked(hwdata_i[15:0], pfo_pkg::MASK_DT_SEL);
        end
        pfo_pkg::OFF_FAULT_A: begin
          next_s.fault_a  = masked(hwdata_i[15:0], pfo_pkg::MASK_FAULT);
          soft_release[0] = 1'b1;
        end
        pfo_pkg::OFF_FAULT_B: begin
          next_s.fault_b  = masked(hwdata_i[15:0], pfo_pkg::MASK_FAULT);
          soft_release[1] = 1'b1;
        end
        pfo_pkg::OFF_OVERRIDE:   next_s.override = hwdata_i[15:0];
        pfo_pkg::OFF_DUTY_ONE:   next_s.duty[0]  = hwdata_i[15:0];
        pfo_pkg::OFF_DUTY_TWO:   next_s.duty[1]  = hwdata_i[15:0];
        pfo_pkg::OFF_DUTY_THREE: next_s.duty[2]  = hwdata_i[15:0];
        pfo_pkg::OFF_DUTY_FOUR:  next_s.duty[3]  = hwdata_i[15:0];
        pfo_pkg::OFF_IRQ_CLEAR:  clear = hwdata_i[pfo_pkg::IRQ_WIDTH-1:0];
        pfo_pkg::OFF_IRQ_ENABLE: next_s.irq_enable = hwdata_i[pfo_pkg::IRQ_WIDTH-1:0];
        default: begin
        end
      endcase
    end
    next_s.wr_pend = 1'b0;

    // Address phase: zero wait states, read data registered for the data phase
    next_s.ready = 1'b1;
    next_s.resp  = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      if (hwrite_i) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr_i[7:0];
      end else begin
        next_s.rdata = read_value(s, haddr_i[7:0]);
      end
    end

    // Fault mode selection per input
    mode_cycle[0] = s.fault_a[pfo_pkg::FAULT_MODE_BIT];
    mode_cycle[1] = s.fault_b[pfo_pkg::FAULT_MODE_BIT];

    // Latched mode: a software write to the control register releases it only
    // once the pin is quiet; a still-asserted pin keeps it set
    for (int f = 0; f < 2; f++) begin
      if (soft_release[f] || mode_cycle[f]) begin
        next_s.latched[f] = 1'b0;
      end
      if (asserted[f] && !mode_cycle[f]) begin
        next_s.latched[f] = 1'b1;
      end
      // Cycle mode: held while asserted, dropped at a period start
      if (period_start_i || !mode_cycle[f]) begin
        next_s.cycle[f] = 1'b0;
      end
      if (asserted[f] && mode_cycle[f]) begin
        next_s.cycle[f] = 1'b1;
      end
    end

    // Sticky fault events; a new event beats a clear in the same cycle
    events[pfo_pkg::IRQ_FAULT_A] = asserted[0] & ~s.seen[0];
    events[pfo_pkg::IRQ_FAULT_B] = asserted[1] & ~s.seen[1];
    next_s.irq_status = (s.irq_status & ~clear) | events;
    next_s.irq        = |(next_s.irq_status & next_s.irq_enable);

    // Pin levels, fault A checked first
    for (int p = 0; p < pfo_pkg::PAIRS; p++) begin
      fa_on = s.fault_a[pfo_pkg::PAIR_ENABLE_LSB + p]
            & (next_s.latched[0] | next_s.cycle[0]);
      fb_on = s.fault_b[pfo_pkg::PAIR_ENABLE_LSB + p]
            & (next_s.latched[1] | next_s.cycle[1]);
      next_s.high[p] = pin_level(fa_on, fb_on, s.fault_a, s.fault_b, s.override,
                                 dt_high[p], pin_pos(p, 1'b1));
      next_s.low[p]  = pin_level(fa_on, fb_on, s.fault_a, s.fault_b, s.override,
                                 dt_low[p], pin_pos(p, 1'b0));
    end
  end

  // ******************************************************
  // State register
  // ******************************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s            <= '0;
      s.dt_select  <= pfo_pkg::RST_DT_SELECT;
      s.fault_a    <= pfo_pkg::RST_FAULT;
      s.fault_b    <= pfo_pkg::RST_FAULT;
      s.override   <= pfo_pkg::RST_OVERRIDE;
      s.duty       <= {4{pfo_pkg::RST_DUTY}};
      s.irq_status <= pfo_pkg::RST_IRQ;
      s.irq_enable <= pfo_pkg::RST_IRQ;
      s.ready      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ******************************************************
  // Outputs, all from flip-flops
  // ******************************************************
  assign hreadyout_o        = s.ready;
  assign hresp_o            = s.resp;
  assign hrdata_o           = s.rdata;
  assign high_side_output_o = s.high;
  assign low_side_output_o  = s.low;
  assign duty_value_one_o   = s.duty[0];
  assign duty_value_two_o   = s.duty[1];
  assign duty_value_three_o = s.duty[2];
  assign duty_value_four_o  = s.duty[3];
  assign irq_o              = s.irq;

endmodule : pfo_top

`default_nettype wire

// *** testbench/pfo_stage_model.sv ***
// Power stage and fault source model facing the conditioned PWM pins
`timescale 1ns/1ps
`default_nettype none

module pfo_stage_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] high_i,
  input  wire logic [3:0] low_i,
  input  wire logic [3:0] independent_i,
  input  wire logic       fault_a_req_i,
  input  wire logic       fault_b_req_i,
  output logic            fault_a_b_o,
  output logic            fault_b_b_o,
  output logic            shoot_o
);
  // Trip lines idle high, shoot flag starts clear
  initial begin
    fault_a_b_o = 1'b1;
    fault_b_b_o = 1'b1;
    shoot_o = 1'b0;
  end

  // Trip lines pulled low while a fault is requested; leg watch is sticky
  always @(posedge clk_i) begin
    fault_a_b_o <= !fault_a_req_i;
    fault_b_b_o <= !fault_b_req_i;
    // Both switches of a complementary leg on together would short the rail
    if ((|(high_i & low_i & ~independent_i)) === 1'b1) begin
      shoot_o <= 1'b1;
    end
  end
endmodule // pfo_stage_model

`default_nettype wire

// *** testbench/pfo_top_monitor.sv ***
// Concurrent checks on the bus and duty ports of the PWM conditioning top
`timescale 1ns/1ps
`default_nettype none

module pfo_top_monitor (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic        fault_a_b_i,
  input wire logic        fault_b_b_i,
  input wire logic [3:0]  high_side_output_o,
  input wire logic [15:0] duty_value_one_o,
  input wire logic [15:0] duty_value_two_o,
  input wire logic [15:0] duty_value_three_o,
  input wire logic [15:0] duty_value_four_o,
  input wire logic        irq_o
);
  // ******************************************************
  // Address phase decode
  // ******************************************************
  logic       wr_p;
  logic       rd_p;
  logic [7:0] off;
  assign wr_p = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  assign rd_p = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign off  = haddr_i[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ******************************************************
  // Assertions
  // ******************************************************
  resp_okay_a : assert property (hresp_o == 1'b0) else $error("bus response not okay");
  zero_wait_a : assert property (hreadyout_o) else $error("slave inserted a wait state");
  rdata_upper_a : assert property (hrdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  reset_clear_a : assert property ($rose(rst_b_i) |->
    (duty_value_one_o | duty_value_two_o | duty_value_three_o | duty_value_four_o) == 16'h0000
    && high_side_output_o == 4'h0) else $error("outputs not cleared by reset");
  duty_one_wr_a : assert property (wr_p && off == pfo_pkg::OFF_DUTY_ONE |=>
    ##1 duty_value_one_o == $past(hwdata_i[15:0])) else $error("duty one not written");
  duty_two_wr_a : assert property (wr_p && off == pfo_pkg::OFF_DUTY_TWO |=>
    ##1 duty_value_two_o == $past(hwdata_i[15:0])) else $error("duty two not written");
  duty_three_wr_a : assert property (wr_p && off == pfo_pkg::OFF_DUTY_THREE |=>
    ##1 duty_value_three_o == $past(hwdata_i[15:0])) else $error("duty three not written");
  duty_four_wr_a : assert property (wr_p && off == pfo_pkg::OFF_DUTY_FOUR |=>
    ##1 duty_value_four_o == $past(hwdata_i[15:0])) else $error("duty four not written");
  duty_two_rd_a : assert property (rd_p && off == pfo_pkg::OFF_DUTY_TWO |=>
    hrdata_o == {16'h0000, $past(duty_value_two_o)}) else $error("duty two read wrong");

  // Main scenarios reached
  cover property (wr_p);
  cover property ($fell(fault_a_b_i));
  cover property ($fell(fault_b_b_i));
  cover property ($rose(irq_o));
endmodule // pfo_top_monitor

bind pfo_top pfo_top_monitor pfo_top_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .fault_a_b_i(fault_a_b_i), .fault_b_b_i(fault_b_b_i),
  .high_side_output_o(high_side_output_o), .duty_value_one_o(duty_value_one_o),
  .duty_value_two_o(duty_value_two_o), .duty_value_three_o(duty_value_three_o),
  .duty_value_four_o(duty_value_four_o), .irq_o(irq_o));

`default_nettype wire

// *** testbench/pfo_top_test.sv ***
// Self-checking bench of the PWM fault, override and dead-time block
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

module pfo_top_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] gen_h = 4'h0;
  logic pstart = 1'b0;
  logic [7:0] dta = 8'h04;
  logic [7:0] dtb = 8'h08;
  logic fa_req = 1'b0;
  logic fb_req = 1'b0;
  logic [3:0] indep = 4'h0;
  wire logic hrdy;
  wire logic fa_b;
  wire logic fb_b;
  wire logic shoot;
  wire logic irq;
  wire logic [31:0] hrdata;
  wire logic [3:0] hi;
  wire logic [3:0] lo;
  wire logic [15:0] duty [4];
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  pfo_top pfo_top_i (.clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata),
    .gen_high_i(gen_h), .gen_low_i(~gen_h), .pair_independent_i(indep),
    .period_start_i(pstart), .dt_a_cycles_i(dta), .dt_b_cycles_i(dtb),
    .fault_a_b_i(fa_b), .fault_b_b_i(fb_b), .high_side_output_o(hi),
    .low_side_output_o(lo), .duty_value_one_o(duty[0]), .duty_value_two_o(duty[1]),
    .duty_value_three_o(duty[2]), .duty_value_four_o(duty[3]), .irq_o(irq));

  pfo_stage_model pfo_stage_model_i (.clk_i(clk), .high_i(hi), .low_i(lo),
    .independent_i(indep), .fault_a_req_i(fa_req), .fault_b_req_i(fb_req),
    .fault_a_b_o(fa_b), .fault_b_b_o(fb_b), .shoot_o(shoot));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ******************************************************
  // Bus and timing helpers
  // ******************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse;
    @(posedge clk);
    pstart <= 1'b1;
    @(posedge clk);
    pstart <= 1'b0;
  endtask

  // Cycles from a generator edge on pair one until the incoming side turns on
  task automatic dt_meas(input logic r, output int n);
    n = 0;
    @(posedge clk);
    gen_h[0] <= r;
    do begin
      @(posedge clk);
      n++;
    end while (((r ? hi[0] : lo[0]) !== 1'b1) && n < 60);
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_regs;
    rdchk(pfo_pkg::OFF_OVERRIDE, 32'h0000_FF00);
    rdchk(pfo_pkg::OFF_DUTY_THREE, 32'h0000_0000);
    wr(pfo_pkg::OFF_DT_SELECT, 32'hFFFF_FFFF);
    rdchk(pfo_pkg::OFF_DT_SELECT, 32'h0000_00FF);
    wr(pfo_pkg::OFF_FAULT_B, 32'hFFFF_FFFF);
    rdchk(pfo_pkg::OFF_FAULT_B, 32'h0000_FF8F);
    wr(pfo_pkg::OFF_FAULT_B, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(pfo_pkg::OFF_DUTY_ONE + 8'(4 * i), 32'h0000_A5C0 + i);
      rdchk(pfo_pkg::OFF_DUTY_ONE + 8'(4 * i), 32'h0000_A5C0 + i);
      `CHK(duty[i], 16'hA5C0 + 16'(i))
    end
    $display("t_regs done");
  endtask

  // Unit B is the longer one, so the edge delays differ by the unit gap
  task automatic t_deadtime;
    int na;
    int nb;
    int ia;
    int ib;
    wr(pfo_pkg::OFF_DT_SELECT, 32'h0000_0002);
    dt_meas(1'b1, nb);
    dt_meas(1'b0, ia);
    wr(pfo_pkg::OFF_DT_SELECT, 32'h0000_0001);
    dt_meas(1'b1, na);
    dt_meas(1'b0, ib);
    `CHK(nb - na, dtb - dta)
    `CHK(ib - ia, dtb - dta)
    `CHK(hi[0], 1'b0)
    `CHK(shoot, 1'b0)
    $display("t_deadtime done");
  endtask

  task automatic t_manual;
    wr(pfo_pkg::OFF_OVERRIDE, 32'h0000_005A);
    wait_c(3);
    `CHK(hi, 4'b0011)
    `CHK(lo, 4'b1100)
    wr(pfo_pkg::OFF_OVERRIDE, 32'h0000_FF5A);
    wait_c(3);
    `CHK(hi, 4'b0000)
    `CHK(lo, 4'b1111)
    wr(pfo_pkg::OFF_OVERRIDE, 32'h0000_0000);
    wait_c(3);
    `CHK(lo, 4'b0000)
    $display("t_manual done");
  endtask

  // Latched trip on pair one only; pair two levels set but not enabled
  task automatic t_fault_a;
    wr(pfo_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    wr(pfo_pkg::OFF_FAULT_A, 32'h0000_0A01);
    fa_req <= 1'b1;
    wait_c(6);
    fa_req <= 1'b0;
    wait_c(6);
    `CHK(hi[0], 1'b1)
    `CHK(hi[1], 1'b0)
    `CHK(lo, 4'b0000)
    `CHK(irq, 1'b1)
    rdchk(pfo_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    wr(pfo_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
    wait_c(2);
    `CHK(irq, 1'b0)
    wr(pfo_pkg::OFF_FAULT_A, 32'h0000_0A01);
    wait_c(3);
    `CHK(hi, 4'b0000)
    $display("t_fault_a done");
  endtask

  // Both trips in cycle mode; A wins on pair one, B alone drives pair two
  task automatic t_fault_b;
    wr(pfo_pkg::OFF_FAULT_A, 32'h0000_0281);
    wr(pfo_pkg::OFF_FAULT_B, 32'h0000_0983);
    fa_req <= 1'b1;
    fb_req <= 1'b1;
    wait_c(6);
    `CHK(hi, 4'b0011)
    `CHK(lo, 4'b0000)
    fa_req <= 1'b0;
    wait_c(4);
    pulse;
    wait_c(3);
    `CHK(lo, 4'b0001)
    `CHK(hi, 4'b0010)
    fb_req <= 1'b0;
    wait_c(6);
    `CHK(lo, 4'b0001)
    pulse;
    wait_c(3);
    `CHK(lo | hi, 4'b0000)
    rdchk(pfo_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    wr(pfo_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
    wait_c(2);
    `CHK(irq, 1'b0)
    // Latched trip B keeps pair one forced after the pin clears
    wr(pfo_pkg::OFF_FAULT_B, 32'h0000_0101);
    fb_req <= 1'b1;
    wait_c(6);
    fb_req <= 1'b0;
    wait_c(6);
    `CHK(lo, 4'b0001)
    wr(pfo_pkg::OFF_FAULT_B, 32'h0000_0000);
    $display("t_fault_b done");
  endtask

  // Independent pair four skips dead time, low side from its own input
  task automatic t_indep;
    indep <= 4'h8;
    wr(pfo_pkg::OFF_OVERRIDE, 32'h0000_FF00);
    gen_h[3] <= 1'b1;
    wait_c(3);
    `CHK(hi, 4'b1000)
    `CHK(lo, 4'b0111)
    $display("t_indep done");
  endtask

  // ******************************************************
  // Sequence, timeout and verdict
  // ******************************************************
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_deadtime;
    t_manual;
    t_fault_a;
    t_fault_b;
    t_indep;
    complete_run;
  end

  // Hang guard, well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      complete_run;
    end
  end
endmodule // pfo_top_test

`default_nettype wire
